// [dac_ctrl_pkg.sv]
// What this block does
// - Command 1100b loads the five channel select bits, bit n for channel n.
// - Write-code goes to register B if the channel's select bit is set, else A.
// - Only channels with their select bit set follow toggle bit and toggle pin.
// - Toggle updates happen on transitions only, never on steady levels.
// - Command 1101b taking the toggle bit from one to zero loads from A.
// - The toggle bit going from zero to one loads selected channels from B.
// - Toggle pin falling edge loads from A, rising edge loads from B.
// - Command 1001b or a low load strobe updates clear bits from A, set from B.
// - Serial output repeats serial input 32 rising edges later, on falling edges.
// - Command 1111b changes nothing; host sends it to unaddressed devices.
// - Serial output is driven only while the select line is low.
// - Echo word is fault status, then command, address and 16 data bits.
// - A 24-bit frame echoes the same layout with only 8 data bits.
// - Fault bits set on detection, shift out next transaction, refresh each one.
// - A fault cleared by an instruction still shows in the next echo, and shows as clear in the one after.
// - Status bits zero to four flag open circuit on the same channel.
// - Status bit five flags overtemperature and engages thermal shutdown.
// - Power limit on high ranges sets bit six and forces range to 100mA.
// - Frame length not 24 or a multiple of 32 sets bit seven, is discarded.
// - Channel select bits reset to zero so writes go to register A.
// - Open-drain fault output pulls low on a fault, released at select rise.
// - Configuration bits disable open, power and thermal checks, pick ext reference.
package dac_ctrl_pkg;
   localparam int CHANNELS = 5;
   localparam int CODE_BITS = 16;
   localparam int FRAME_BITS = 32;
   localparam logic [4:0] SHORT_FRAME_BITS = 5'h18;
   localparam int CMD_MSB = 23;
   localparam int CMD_LSB = 20;
   localparam int ADDR_MSB = 19;
   localparam int ADDR_LSB = 16;
   localparam logic [3:0] CMD_WRITE_CODE = 4'h0;
   localparam logic [3:0] CMD_CONFIG = 4'h7;
   localparam logic [3:0] CMD_UPDATE_ALL = 4'h9;
   localparam logic [3:0] CMD_TOGGLE_SELECT = 4'hC;
   localparam logic [3:0] CMD_GLOBAL_TOGGLE = 4'hD;
   localparam logic [3:0] CMD_NOP = 4'hF;
   localparam int GLOBAL_TOGGLE_POS = 0;
   localparam int CFG_EXT_REF_POS = 0;
   localparam int CFG_THERMAL_OFF_POS = 1;
   localparam int CFG_POWER_OFF_POS = 2;
   localparam int CFG_OPEN_OFF_POS = 3;
   localparam int STAT_OVERTEMP_POS = 5;
   localparam int STAT_POWER_POS = 6;
   localparam int STAT_LENGTH_POS = 7;
   localparam logic [4:0] TOGGLE_SELECT_RESET = 5'h00;
   localparam logic GLOBAL_TOGGLE_RESET = 1'h0;
   localparam logic [3:0] CONFIG_RESET = 4'h0;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [15:0] CODE_RESET = 16'h0000;
   localparam logic [4:0] PIN_SYNC_RESET = 5'h1C;
endpackage

// [frame_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface frame_if;
   logic frame_start;
   logic frame_done;
   logic frame_valid;
   logic [23:0] frame_word;
   logic [7:0] echo_status;
   modport port
   (
      output frame_start,
      output frame_done,
      output frame_valid,
      output frame_word,
      input echo_status
   );
   modport core
   (
      input frame_start,
      input frame_done,
      input frame_valid,
      input frame_word,
      output echo_status
   );
endinterface
`default_nettype wire

// [input_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module input_sync
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed
   {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } sync_state_type;

   sync_state_type st;
   sync_state_type next_st;

   // The first stage feeds only the second stage, never any other logic.
   always_comb
   begin
      next_st.first = async_in;
      next_st.second = st.first;
      if (srst)
      begin
         next_st.first = RESET_VALUE;
         next_st.second = RESET_VALUE;
      end
   end

   always_ff @(posedge clk)
   begin
      st <= next_st;
   end

   assign sync_out = st.second;
endmodule
`default_nettype wire

// [serial_frame_port.sv]
`timescale 1ns/10ps
`default_nettype none
module serial_frame_port
(
   input wire logic clk,
   input wire logic srst,
   input wire logic sck_s,
   input wire logic sdi_s,
   input wire logic select_s,
   frame_if.port fr,
   output logic sdo_out,
   output logic sdo_oe
);
   typedef struct packed
   {
      logic [31:0] shreg;
      logic sdo;
      logic active;
      logic [4:0] count;
      logic seen_full;
      logic sck_prev;
      logic select_prev;
      logic [23:0] prev_word;
      logic start;
      logic done;
      logic valid;
      logic [23:0] word;
   } port_state_type;

   port_state_type st;
   port_state_type next_st;
   logic sck_rise;
   logic sck_fall;
   logic sel_fall;
   logic sel_rise;
   logic len_ok;

   assign sck_rise = sck_s & ~st.sck_prev;
   assign sck_fall = ~sck_s & st.sck_prev;
   assign sel_fall = ~select_s & st.select_prev;
   assign sel_rise = select_s & ~st.select_prev;
   // The counter wraps every 32 bits, so any multiple of 32 ends at zero.
   assign len_ok = (st.count == 5'h00 && st.seen_full)
      || (st.count == dac_ctrl_pkg::SHORT_FRAME_BITS && !st.seen_full);

   always_comb
   begin
      next_st = st;
      next_st.start = 1'h0;
      next_st.done = 1'h0;
      next_st.sck_prev = sck_s;
      next_st.select_prev = select_s;
      if (sel_fall)
      begin
         next_st.shreg = {fr.echo_status, st.prev_word};
         next_st.sdo = fr.echo_status[7];
         next_st.active = 1'h1;
         next_st.count = 5'h00;
         next_st.seen_full = 1'h0;
         next_st.start = 1'h1;
      end
      else if (st.active)
      begin
         if (sck_rise)
         begin
            next_st.shreg = {st.shreg[30:0], sdi_s};
            next_st.count = 5'(st.count + 5'h01);
            if (st.count == 5'h1F)
            begin
               next_st.seen_full = 1'h1;
            end
         end
         if (sck_fall)
         begin
            next_st.sdo = st.shreg[31];
         end
      end
      if (sel_rise && st.active)
      begin
         next_st.active = 1'h0;
         next_st.done = 1'h1;
         next_st.valid = len_ok;
         next_st.word = st.shreg[23:0];
         // A 24-bit instruction and the low 24 bits of a 32-bit one line up.
         if (len_ok)
         begin
            next_st.prev_word = st.shreg[23:0];
         end
      end
      if (srst)
      begin
         next_st = '0;
         next_st.sck_prev = 1'h0;
         next_st.select_prev = 1'h1;
      end
   end

   always_ff @(posedge clk)
   begin
      st <= next_st;
   end

   assign sdo_out = st.sdo;
   assign sdo_oe = st.active;
   assign fr.frame_start = st.start;
   assign fr.frame_done = st.done;
   assign fr.frame_valid = st.valid;
   assign fr.frame_word = st.word;
endmodule
`default_nettype wire

// [dac_toggle_echo_fault.sv]
`timescale 1ns/10ps
`default_nettype none
module dac_toggle_echo_fault
(
   input wire logic clk,
   input wire logic srst,
   input wire logic sck,
   input wire logic sdi,
   input wire logic select_and_load,
   input wire logic toggle_input_pin,
   input wire logic load_all_strobe_n,
   input wire logic [4:0] open_circuit_raw,
   input wire logic overtemp_raw,
   input wire logic [4:0] power_limit_raw,
   input wire logic [4:0] range_high,
   output logic sdo_out,
   output logic sdo_oe,
   output logic fault_out,
   output logic fault_oe,
   output logic [79:0] dac_code,
   output logic [4:0] dac_update,
   output logic [4:0] range_force_low,
   output logic thermal_shutdown,
   output logic open_detect_off,
   output logic power_limit_off,
   output logic thermal_protect_off,
   output logic ext_reference
);
   typedef struct packed
   {
      logic [4:0] channel_toggle_select;
      logic global_toggle_bit;
      logic [3:0] config_bits;
      logic [4:0][15:0] reg_a;
      logic [4:0][15:0] reg_b;
      logic [4:0][15:0] dac;
      logic [4:0] update;
      logic [7:0] fault_status;
      logic fault_active;
      logic [6:0] live_prev;
      logic toggle_prev;
      logic strobe_prev;
   } core_state_type;

   core_state_type st;
   core_state_type next_st;
   frame_if fr();
   logic [4:0] pins_s;
   logic [10:0] detect_s;
   logic [4:0] open_live;
   logic overtemp_live;
   logic [4:0] power_chan;
   logic [6:0] live;
   logic bad_length;
   logic [3:0] cmd;
   logic [3:0] addr;
   logic [15:0] data;
   logic [4:0] load_a;
   logic [4:0] load_b;

   input_sync #(.WIDTH(5), .RESET_VALUE(dac_ctrl_pkg::PIN_SYNC_RESET)) pin_sync
   (
      .clk(clk),
      .srst(srst),
      .async_in({select_and_load, toggle_input_pin, load_all_strobe_n, sck, sdi}),
      .sync_out(pins_s)
   );

   // Detector levels come from analog circuits with no relation to clk.
   input_sync #(.WIDTH(11), .RESET_VALUE(11'h000)) detect_sync
   (
      .clk(clk),
      .srst(srst),
      .async_in({power_limit_raw, overtemp_raw, open_circuit_raw}),
      .sync_out(detect_s)
   );

   serial_frame_port port
   (
      .clk(clk),
      .srst(srst),
      .sck_s(pins_s[1]),
      .sdi_s(pins_s[0]),
      .select_s(pins_s[4]),
      .fr(fr.port),
      .sdo_out(sdo_out),
      .sdo_oe(sdo_oe)
   );

   assign cmd = fr.frame_word[dac_ctrl_pkg::CMD_MSB:dac_ctrl_pkg::CMD_LSB];
   assign addr = fr.frame_word[dac_ctrl_pkg::ADDR_MSB:dac_ctrl_pkg::ADDR_LSB];
   assign data = fr.frame_word[15:0];
   assign fr.echo_status = st.fault_status;

   assign open_live = detect_s[4:0]
      & {5{~st.config_bits[dac_ctrl_pkg::CFG_OPEN_OFF_POS]}};
   assign overtemp_live = detect_s[5]
      & ~st.config_bits[dac_ctrl_pkg::CFG_THERMAL_OFF_POS];
   assign power_chan = detect_s[10:6] & range_high
      & {5{~st.config_bits[dac_ctrl_pkg::CFG_POWER_OFF_POS]}};
   assign live = {|power_chan, overtemp_live, open_live};
   assign bad_length = fr.frame_done & ~fr.frame_valid;

   always_comb
   begin
      next_st = st;
      load_a = 5'h00;
      load_b = 5'h00;
      next_st.toggle_prev = pins_s[3];
      next_st.strobe_prev = pins_s[2];
      next_st.live_prev = live;

      // Instructions only act once the frame has closed with a legal length.
      if (fr.frame_done && fr.frame_valid)
      begin
         case (cmd)
            dac_ctrl_pkg::CMD_WRITE_CODE:
            begin
               if (addr < 4'h5)
               begin
                  if (st.channel_toggle_select[addr[2:0]])
                  begin
                     next_st.reg_b[addr[2:0]] = data;
                  end
                  else
                  begin
                     next_st.reg_a[addr[2:0]] = data;
                  end
               end
            end
            dac_ctrl_pkg::CMD_TOGGLE_SELECT:
            begin
               next_st.channel_toggle_select = data[4:0];
            end
            dac_ctrl_pkg::CMD_GLOBAL_TOGGLE:
            begin
               next_st.global_toggle_bit = data[dac_ctrl_pkg::GLOBAL_TOGGLE_POS];
               if (st.global_toggle_bit && !data[dac_ctrl_pkg::GLOBAL_TOGGLE_POS])
               begin
                  load_a = load_a | st.channel_toggle_select;
               end
               if (!st.global_toggle_bit && data[dac_ctrl_pkg::GLOBAL_TOGGLE_POS])
               begin
                  load_b = load_b | st.channel_toggle_select;
               end
            end
            dac_ctrl_pkg::CMD_UPDATE_ALL:
            begin
               load_a = load_a | ~st.channel_toggle_select;
               load_b = load_b | st.channel_toggle_select;
            end
            dac_ctrl_pkg::CMD_CONFIG:
            begin
               next_st.config_bits = data[3:0];
            end
            dac_ctrl_pkg::CMD_NOP:
            begin
               next_st.update = 5'h00;
            end
            default:
            begin
               next_st.update = 5'h00;
            end
         endcase
      end

      // Toggle pin and strobe act on edges only; a held level does nothing.
      if (st.toggle_prev && !pins_s[3])
      begin
         load_a = load_a | st.channel_toggle_select;
      end
      if (!st.toggle_prev && pins_s[3])
      begin
         load_b = load_b | st.channel_toggle_select;
      end
      if (st.strobe_prev && !pins_s[2])
      begin
         load_a = load_a | ~st.channel_toggle_select;
         load_b = load_b | st.channel_toggle_select;
      end

      // If two sources hit in one cycle, register B wins for that channel.
      for (int i = 0; i < dac_ctrl_pkg::CHANNELS; i++)
      begin
         if (load_b[i])
         begin
            next_st.dac[i] = st.reg_b[i];
         end
         else if (load_a[i])
         begin
            next_st.dac[i] = st.reg_a[i];
         end
      end
      next_st.update = load_a | load_b;

      // A new transaction refreshes the word; live conditions set it again.
      next_st.fault_status = (fr.frame_start ? dac_ctrl_pkg::STATUS_RESET : st.fault_status)
         | {bad_length, live};
      // Clearing at the frame start lets a removed fault read clear next time.
      if (fr.frame_start)
      begin
         next_st.fault_status[dac_ctrl_pkg::STAT_LENGTH_POS] = bad_length;
      end

      // New faults pull the pin low; a select rise frees it, even while hot.
      next_st.fault_active = (fr.frame_done ? 1'h0 : st.fault_active)
         | (|(live & ~st.live_prev)) | bad_length;

      if (srst)
      begin
         next_st = '0;
         next_st.channel_toggle_select = dac_ctrl_pkg::TOGGLE_SELECT_RESET;
         next_st.global_toggle_bit = dac_ctrl_pkg::GLOBAL_TOGGLE_RESET;
         next_st.config_bits = dac_ctrl_pkg::CONFIG_RESET;
         next_st.fault_status = dac_ctrl_pkg::STATUS_RESET;
         next_st.reg_a = {5{dac_ctrl_pkg::CODE_RESET}};
         next_st.reg_b = {5{dac_ctrl_pkg::CODE_RESET}};
         next_st.dac = {5{dac_ctrl_pkg::CODE_RESET}};
         next_st.toggle_prev = 1'h1;
         next_st.strobe_prev = 1'h1;
      end
   end

   always_ff @(posedge clk)
   begin
      st <= next_st;
   end

   assign fault_out = 1'h0;
   assign fault_oe = st.fault_active;
   assign dac_code = st.dac;
   assign dac_update = st.update;
   assign range_force_low = power_chan;
   assign thermal_shutdown = overtemp_live;
   assign open_detect_off = st.config_bits[dac_ctrl_pkg::CFG_OPEN_OFF_POS];
   assign power_limit_off = st.config_bits[dac_ctrl_pkg::CFG_POWER_OFF_POS];
   assign thermal_protect_off = st.config_bits[dac_ctrl_pkg::CFG_THERMAL_OFF_POS];
   assign ext_reference = st.config_bits[dac_ctrl_pkg::CFG_EXT_REF_POS];
endmodule
`default_nettype wire

// [dac_toggle_echo_fault_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module dac_toggle_echo_fault_monitor
(
   input wire logic clk,
   input wire logic srst,
   input wire logic select_and_load,
   input wire logic overtemp_raw,
   input wire logic [4:0] range_high,
   input wire logic sdo_oe,
   input wire logic fault_out,
   input wire logic fault_oe,
   input wire logic [4:0] dac_update,
   input wire logic [4:0] range_force_low,
   input wire logic thermal_shutdown,
   input wire logic power_limit_off,
   input wire logic thermal_protect_off
);
   default clocking mon_cb @(posedge clk);
   endclocking
   default disable iff (srst);
   fault_data_low_a: assert property (fault_out == 1'b0)
      else $error("fault pin data is not low");
   fault_release_a: assert property ($fell(fault_oe) |-> select_and_load)
      else $error("fault pin released inside a frame");
   fault_pull_a: assert property ($rose(thermal_shutdown) |-> ##[0:1] fault_oe)
      else $error("fault pin not pulled on overtemperature");
   sdo_idle_a: assert property (select_and_load [*5] |-> !sdo_oe)
      else $error("serial output driven while deselected");
   sdo_active_a: assert property (!select_and_load [*5] |-> sdo_oe)
      else $error("serial output not driven in frame");
   update_pulse_a: assert property (dac_update != 5'h00 |=> dac_update == 5'h00)
      else $error("update repeated on a steady level");
   range_force_a: assert property ((range_force_low & ~range_high) == 5'h00)
      else $error("range forced on a low range channel");
   power_off_a: assert property (power_limit_off |-> range_force_low == 5'h00)
      else $error("power limit acts while disabled");
   thermal_off_a: assert property (thermal_protect_off |-> !thermal_shutdown)
      else $error("thermal shutdown while disabled");
   thermal_sync_a: assert property ($rose(overtemp_raw) |=> !thermal_shutdown)
      else $error("overtemperature not synchronised");
   thermal_follow_a: assert property
      ((overtemp_raw && !thermal_protect_off) [*4] |-> thermal_shutdown)
      else $error("thermal shutdown missing");
endmodule
bind dac_toggle_echo_fault dac_toggle_echo_fault_monitor dac_toggle_echo_fault_monitor_i
(
   .clk(clk), .srst(srst), .select_and_load(select_and_load), .overtemp_raw(overtemp_raw),
   .range_high(range_high), .sdo_oe(sdo_oe), .fault_out(fault_out), .fault_oe(fault_oe),
   .dac_update(dac_update), .range_force_low(range_force_low),
   .thermal_shutdown(thermal_shutdown), .power_limit_off(power_limit_off),
   .thermal_protect_off(thermal_protect_off)
);
`default_nettype wire

// [spi_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module spi_host_model
(
   output var logic sck,
   output var logic sdi,
   output var logic select_and_load,
   input wire logic sdo_out,
   input wire logic sdo_oe
);
   initial
   begin
      sck = 1'b0;
      sdi = 1'b0;
      select_and_load = 1'b1;
   end
   // The link clock rests low between frames; the echo line has a pull-up when released.
   task automatic frame(input int n, input logic [95:0] word, output logic [95:0] echo);
      echo = '0;
      select_and_load = 1'b0;
      #200;
      for (int i = n - 1; i >= 0; i--)
      begin
         sdi = word[i];
         #160;
         sck = 1'b1;
         echo = {echo[94:0], sdo_oe ? sdo_out : 1'b1};
         #160;
         sck = 1'b0;
      end
      #200;
      select_and_load = 1'b1;
      sdi = ~sdi;
      #400;
   endtask
endmodule
`default_nettype wire

// [tb_dac_toggle_echo_fault.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_dac_toggle_echo_fault;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic tgl = 1'b1;
   logic strobe_n = 1'b1;
   logic overtemp_raw = 1'b0;
   logic [4:0] oc = 5'h00;
   logic [4:0] pl = 5'h00;
   logic [4:0] rh = 5'h00;
   logic sck, sdi, sel_ld, sdo_out, sdo_oe, fault_out, fault_oe, thermal_shutdown;
   logic open_off, power_off, thermal_off, ext_ref;
   logic [79:0] dac_code;
   logic [4:0] dac_update, force_low, sel;
   logic [15:0] a [5];
   logic [15:0] b [5];
   logic [15:0] dac [5] = '{default: 16'h0000};
   logic [23:0] prev = 24'h000000;
   logic [31:0] rng = 32'hF23A;
   logic [31:0] r;
   int failures = 0;
   int n_compared = 0;
   initial
   begin
      forever #20 clk = ~clk;
   end
   dac_toggle_echo_fault dac_toggle_echo_fault_i (.clk(clk), .srst(srst), .sck(sck),
      .sdi(sdi), .select_and_load(sel_ld), .toggle_input_pin(tgl),
      .load_all_strobe_n(strobe_n), .open_circuit_raw(oc), .overtemp_raw(overtemp_raw),
      .power_limit_raw(pl), .range_high(rh), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
      .fault_out(fault_out), .fault_oe(fault_oe), .dac_code(dac_code),
      .dac_update(dac_update), .range_force_low(force_low),
      .thermal_shutdown(thermal_shutdown), .open_detect_off(open_off),
      .power_limit_off(power_off), .thermal_protect_off(thermal_off),
      .ext_reference(ext_ref));
   spi_host_model spi_host_model_i (.sck(sck), .sdi(sdi), .select_and_load(sel_ld),
      .sdo_out(sdo_out), .sdo_oe(sdo_oe));
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   // Channels in mask load from B where from_b is set, else from A.
   function automatic logic [79:0] upd(input logic [4:0] mask, input logic [4:0] from_b);
      logic [79:0] v;
      for (int k = 0; k < 5; k++)
      begin
         if (mask[k])
            dac[k] = from_b[k] ? b[k] : a[k];
         v[16*k +: 16] = dac[k];
      end
      return v;
   endfunction
   task automatic stop_test();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic cmp_code(input logic [79:0] got, input logic [79:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Frames start just after a clock edge so no pin moves on a sampling edge.
   task automatic send(input int n, input logic [31:0] top, input logic [3:0] cmd,
      input logic [3:0] adr, input logic [15:0] d, input logic [7:0] st);
      logic [95:0] echo;
      logic [31:0] exp;
      @(posedge clk);
      #2;
      spi_host_model_i.frame(n, {32'h0, top, 8'h0, cmd, adr, d}, echo);
      exp = {st, prev};
      if (n < 32)
         cmp_word({8'h0, echo[n-1 -: 24]}, {8'h0, exp[31:8]});
      else
         cmp_word(echo[n-1 -: 32], exp);
      if (n == 64)
         cmp_word(echo[31:0], top);
      if (n == 24 || n % 32 == 0)
         prev = {cmd, adr, d};
   endtask
   task automatic drive(ref logic p, input logic v);
      @(posedge clk);
      #2 p = v;
      repeat (5) @(posedge clk);
   endtask
   initial
   begin
      #3ms;
      failures++;
      stop_test();
   end
   initial
   begin
      repeat (20) @(posedge clk);
      #2 srst = 1'b0;
      repeat (5) @(posedge clk);
      cmp_code(dac_code, 80'h0);
      for (int i = 0; i < 5; i++)
      begin
         r = rnd();
         a[i] = r[15:0];
         send(32, 32'h0, dac_ctrl_pkg::CMD_WRITE_CODE, i[3:0], a[i], 8'h00);
      end
      send(32, 32'h0, dac_ctrl_pkg::CMD_GLOBAL_TOGGLE, 4'h0, 16'h0001, 8'h00);
      send(32, 32'h0, dac_ctrl_pkg::CMD_UPDATE_ALL, 4'h0, 16'h0000, 8'h00);
      cmp_code(dac_code, upd(5'h1F, 5'h00));
      r = rnd();
      sel = r[4:0] | 5'h08;
      send(32, 32'h0, dac_ctrl_pkg::CMD_TOGGLE_SELECT, 4'h0, {11'h0, sel}, 8'h00);
      for (int i = 0; i < 5; i++)
      begin
         r = rnd();
         if (sel[i])
            b[i] = r[15:0];
         else
            a[i] = r[15:0];
         send(32, 32'h0, dac_ctrl_pkg::CMD_WRITE_CODE, i[3:0], r[15:0], 8'h00);
      end
      drive(strobe_n, 1'b0);
      drive(strobe_n, 1'b1);
      cmp_code(dac_code, upd(5'h1F, sel));
      // The pin stays high while the toggle bit is used.
      for (int i = 0; i < 3; i++)
      begin
         send(32, 32'h0, dac_ctrl_pkg::CMD_GLOBAL_TOGGLE, 4'h0, {15'h0, ~i[0]}, 8'h00);
         cmp_code(dac_code, upd(sel, i[0] ? 5'h00 : sel));
      end
      r = rnd();
      b[3] = r[15:0];
      send(32, 32'h0, dac_ctrl_pkg::CMD_WRITE_CODE, 4'h3, b[3], 8'h00);
      send(32, 32'h0, dac_ctrl_pkg::CMD_GLOBAL_TOGGLE, 4'h0, 16'h0001, 8'h00);
      cmp_code(dac_code, upd(5'h00, 5'h00));
      drive(tgl, 1'b0);
      cmp_code(dac_code, upd(sel, 5'h00));
      drive(tgl, 1'b1);
      cmp_code(dac_code, upd(sel, sel));
      r = rnd();
      send(32, 32'h0, dac_ctrl_pkg::CMD_NOP, r[19:16], r[15:0], 8'h00);
      cmp_code(dac_code, upd(5'h00, 5'h00));
      send(64, rnd(), dac_ctrl_pkg::CMD_NOP, 4'h0, 16'h0000, 8'h00);
      send(24, 32'h0, dac_ctrl_pkg::CMD_NOP, 4'h1, r[15:0], 8'h00);
      send(25, 32'h0, dac_ctrl_pkg::CMD_TOGGLE_SELECT, 4'h0, {11'h0, ~sel}, 8'h00);
      cmp_word({31'h0, fault_oe}, 32'h1);
      drive(strobe_n, 1'b0);
      drive(strobe_n, 1'b1);
      cmp_code(dac_code, upd(5'h1F, sel));
      send(32, 32'h0, dac_ctrl_pkg::CMD_NOP, 4'h0, 16'h0000, 8'h80);
      cmp_word({31'h0, fault_oe}, 32'h0);
      send(32, 32'h0, dac_ctrl_pkg::CMD_NOP, 4'h0, 16'h0000, 8'h00);
      drive(overtemp_raw, 1'b1);
      cmp_word({30'h0, thermal_shutdown, fault_oe}, 32'h3);
      drive(overtemp_raw, 1'b0);
      send(32, 32'h0, dac_ctrl_pkg::CMD_NOP, 4'h0, 16'h0000, 8'h20);
      send(32, 32'h0, dac_ctrl_pkg::CMD_NOP, 4'h0, 16'h0000, 8'h00);
      r = rnd();
      @(posedge clk);
      #2 oc = r[4:0] | 5'h01;
      pl = r[9:5];
      rh = r[14:10] | r[9:5];
      repeat (5) @(posedge clk);
      cmp_word({27'h0, force_low}, {27'h0, pl & rh});
      send(32, 32'h0, dac_ctrl_pkg::CMD_NOP, 4'h0, 16'h0000, {1'b0, |pl, 1'b0, oc});
      send(32, 32'h0, dac_ctrl_pkg::CMD_CONFIG, 4'h0, 16'h000F, {1'b0, |pl, 1'b0, oc});
      cmp_word({28'h0, open_off, power_off, thermal_off, ext_ref}, 32'hF);
      // Faults stay live until the config frame executes, so this echo still shows them.
      send(32, 32'h0, dac_ctrl_pkg::CMD_NOP, 4'h0, 16'h0000, {1'b0, |pl, 1'b0, oc});
      send(32, 32'h0, dac_ctrl_pkg::CMD_NOP, 4'h0, 16'h0000, 8'h00);
      stop_test();
   end
endmodule
`default_nettype wire
